//--- arf_ctrl.sv
// Converter control register, start selection, accumulation and result
// registers. Assumes a SAR core outside that converts on conv_start_o and
// returns one result with a done pulse; window compare is also outside.
// The repeat code comes in from the neighbouring configuration register.
`timescale 1ns/1ps
module arf_ctrl
(
	input  wire logic        ref_clk_i,        // System clock, 100 MHz
	input  wire logic        resetn_i,         // Async reset, active low
	input  wire logic [7:0]  sfr_page_i,       // Current SFR page
	input  wire logic [7:0]  sfr_addr_i,       // Byte address
	input  wire logic        sfr_wr_i,         // Byte write strobe
	input  wire logic        sfr_rd_i,         // Byte read strobe
	input  wire logic [7:0]  sfr_wdata_i,      // Byte write data
	input  wire logic        sfr_bit_wr_i,     // Single-bit write strobe
	input  wire logic [7:0]  sfr_bit_addr_i,   // Bit address
	input  wire logic        sfr_bit_val_i,    // Bit write value
	output logic      [7:0]  sfr_rdata_o,      // Read data, next cycle
	input  wire logic        timer1_ovf_i,     // Timer 1 overflow pulse
	input  wire logic        timer2_ovf_i,     // Timer 2 overflow pulse
	input  wire logic        external_convert_start_i, // Start pin
	input  wire logic        sar_done_i,       // SAR result valid pulse
	input  wire logic [11:0] sar_result_i,     // SAR result
	input  wire logic        window_match_i,   // Window compare hit pulse
	input  wire logic [1:0]  repeat_count_i,   // Repeat code, config register
	output logic             conv_start_o,     // Start one conversion
	output logic             converter_enable_o, // Enable to SAR core
	output logic             burst_enable_o,   // Burst mode to SAR core
	output logic             seq_done_o        // Pulse when sequence ends
);
	////////////////////////////////////////////////////////////////////////
	// Register decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r) && (sfr_page_i == arf_pkg::SFR_PAGE);
	endfunction

	function automatic logic [4:0] last_idx(input logic [1:0] rpt);
		case (rpt)
			arf_pkg::RPT_1:  last_idx = 5'h00;
			arf_pkg::RPT_4:  last_idx = 5'h03;
			arf_pkg::RPT_8:  last_idx = 5'h07;
			default:         last_idx = 5'h0F;
		endcase
	endfunction

	arf_fmt_if fmt_bus ();
	arf_format u_format
	(
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.f         (fmt_bus)
	);

	logic [7:0]  cn_q, cn_d, hi_q, hi_d, lo_q, lo_d, rdata_d;
	logic [15:0] acc_q, acc_d;
	logic [4:0]  cnt_q, cnt_d;
	logic        start_q, start_d, done_q, done_d;
	logic [2:0]  ext_q;
	arf_pkg::arf_state_e st_q, st_d;

	////////////////////////////////////////////////////////////////////////
	// Start source selection
	logic       cn_hit, cn_bit_hit, sw_start, ext_rise, trig;
	logic [7:0] cn_wr;
	logic       finish;

	always_comb
	begin
		cn_hit = sfr_wr_i && hit(sfr_addr_i, arf_pkg::ADDR_CTRL);
		cn_bit_hit = sfr_bit_wr_i && sfr_page_i == arf_pkg::SFR_PAGE
			&& sfr_bit_addr_i[7:3] == arf_pkg::ADDR_CTRL[7:3];
		cn_wr = cn_q;
		if (cn_hit)
			cn_wr = sfr_wdata_i;
		else if (cn_bit_hit)
			cn_wr[sfr_bit_addr_i[2:0]] = sfr_bit_val_i;
		sw_start = (cn_hit || cn_bit_hit) && cn_wr[arf_pkg::CN_BUSY];
		ext_rise = ext_q[1] && !ext_q[2];
		// New enable and source apply at once, so one write can start
		case (cn_wr[arf_pkg::CN_CM_HI:arf_pkg::CN_CM_LO])
			arf_pkg::CM_SOFTWARE: trig = sw_start;
			arf_pkg::CM_TIMER1:   trig = timer1_ovf_i;
			arf_pkg::CM_EXTERNAL: trig = ext_rise;
			default:              trig = timer2_ovf_i;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer and registers
	always_comb
	begin
		fmt_bus.ljust = cn_q[arf_pkg::CN_LJUST];
		fmt_bus.rpt = repeat_count_i;
		st_d = st_q;
		acc_d = acc_q;
		cnt_d = cnt_q;
		start_d = 1'b0;
		finish = 1'b0;
		hi_d = hi_q;
		lo_d = lo_q;
		// Busy is owned by the sequencer; writes only request a start
		cn_d = cn_wr;
		cn_d[arf_pkg::CN_BUSY] = cn_q[arf_pkg::CN_BUSY];
		if (sfr_wr_i && hit(sfr_addr_i, arf_pkg::ADDR_RES_HIGH))
			hi_d = sfr_wdata_i;
		if (sfr_wr_i && hit(sfr_addr_i, arf_pkg::ADDR_RES_LOW))
			lo_d = sfr_wdata_i;
		case (st_q)
			arf_pkg::ST_IDLE:
			begin
				if (cn_wr[arf_pkg::CN_ENABLE] && trig)
				begin
					st_d = arf_pkg::ST_CONV;
					acc_d = 16'h0000;
					cnt_d = 5'h00;
					start_d = 1'b1;
				end
			end
			arf_pkg::ST_CONV:
			begin
				if (sar_done_i)
				begin
					acc_d = acc_q + {4'h0, sar_result_i};
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == last_idx(repeat_count_i))
					begin
						finish = 1'b1;
						st_d = arf_pkg::ST_IDLE;
					end
					else if (cn_q[arf_pkg::CN_BURST])
						start_d = 1'b1;
					else
						st_d = arf_pkg::ST_TRIG;
				end
			end
			arf_pkg::ST_TRIG:
			begin
				if (trig)
				begin
					st_d = arf_pkg::ST_CONV;
					start_d = 1'b1;
				end
			end
			default:
				st_d = arf_pkg::ST_IDLE;
		endcase
		// A write that clears enable aborts even a start it carries
		if (!cn_wr[arf_pkg::CN_ENABLE])
		begin
			st_d = arf_pkg::ST_IDLE;
			start_d = 1'b0;
		end
		cn_d[arf_pkg::CN_BUSY] = (st_d != arf_pkg::ST_IDLE);
		// Hardware set wins over a software clear in the same cycle
		if (finish)
			cn_d[arf_pkg::CN_DONE] = 1'b1;
		if (window_match_i && finish)
			cn_d[arf_pkg::CN_WINDOW] = 1'b1;
		// Formatter must see the sum including the result arriving now
		fmt_bus.acc = acc_d;
		done_d = finish;
		rdata_d = 8'h00;
		if (sfr_rd_i && hit(sfr_addr_i, arf_pkg::ADDR_CTRL))
			rdata_d = cn_q;
		else if (sfr_rd_i && hit(sfr_addr_i, arf_pkg::ADDR_RES_HIGH))
			rdata_d = hi_q;
		else if (sfr_rd_i && hit(sfr_addr_i, arf_pkg::ADDR_RES_LOW))
			rdata_d = lo_q;
	end

	// Result bytes latch the formatted sum of the finished sequence
	logic [7:0] hi_n, lo_n;
	assign hi_n = finish ? fmt_bus.hi : hi_d;
	assign lo_n = finish ? fmt_bus.lo : lo_d;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_q <= arf_pkg::ST_IDLE;
			cn_q <= arf_pkg::RST_CTRL;
			hi_q <= arf_pkg::RST_RES_HIGH;
			lo_q <= arf_pkg::RST_RES_LOW;
			acc_q <= 16'h0000;
			cnt_q <= 5'h00;
			start_q <= 1'b0;
			done_q <= 1'b0;
			ext_q <= 3'h0;
			sfr_rdata_o <= 8'h00;
		end
		else
		begin
			st_q <= st_d;
			cn_q <= cn_d;
			hi_q <= hi_n;
			lo_q <= lo_n;
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			start_q <= start_d;
			done_q <= done_d;
			// Two-stage synchroniser, third stage for edge detection
			ext_q <= {ext_q[1:0], external_convert_start_i};
			sfr_rdata_o <= rdata_d;
		end
	end

	assign conv_start_o = start_q;
	assign seq_done_o = done_q;
	assign converter_enable_o = cn_q[arf_pkg::CN_ENABLE];
	assign burst_enable_o = cn_q[arf_pkg::CN_BURST];

	////////////////////////////////////////////////////////////////////////
	// Checks
	sw_start_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(st_q == arf_pkg::ST_IDLE && cn_wr[arf_pkg::CN_ENABLE]
		&& cn_wr[1:0] == arf_pkg::CM_SOFTWARE && sw_start)
		|=> (conv_start_o && cn_q[arf_pkg::CN_BUSY]))
		else $error("software start not taken");
	ext_start_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(st_q == arf_pkg::ST_IDLE && cn_q[7] && cn_q[1:0] != 2'h2
		&& cn_q[1:0] != 2'h0 && !timer1_ovf_i && !timer2_ovf_i
		&& !cn_hit && !cn_bit_hit)
		|=> !conv_start_o)
		else $error("start without selected source");
	done_set_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		finish |=> (cn_q[5] && seq_done_o && !cn_q[4]))
		else $error("done flag not raised at end");
	done_hold_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(cn_q[5] && !cn_hit && !cn_bit_hit) |=> cn_q[5])
		else $error("done flag dropped without software");
	count_end_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		finish |-> (cnt_q == last_idx(repeat_count_i)))
		else $error("sequence ended at wrong count");
	result_load_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(finish && !cn_q[2]) |=> (lo_q == $past(acc_d[7:0])))
		else $error("low byte not loaded with sum");
	bit_write_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(cn_bit_hit && !cn_hit && sfr_bit_addr_i[2:0] == 3'h7)
		|=> (cn_q[7] == $past(sfr_bit_val_i)))
		else $error("bit write to enable lost");
endmodule

//--- arf_ctrl_test.sv
// Self-checking bench for the converter control register and result bytes.
// Assumes SAR core, timers and pin are modelled by pulses on the ports.
`timescale 1ns/1ps
module arf_ctrl_test;
	typedef struct packed
	{
		logic        lj;
		logic [11:0] res;
		logic [7:0]  hi;
		logic [7:0]  lo;
	} arf_row_s;
	logic        ref_clk_i = 1'b0;
	logic        resetn_i;
	logic [7:0]  sfr_page_i;
	logic [7:0]  sfr_addr_i;
	logic        sfr_wr_i;
	logic        sfr_rd_i;
	logic [7:0]  sfr_wdata_i;
	logic        sfr_bit_wr_i;
	logic [7:0]  sfr_bit_addr_i;
	logic        sfr_bit_val_i;
	logic [7:0]  sfr_rdata_o;
	logic        timer1_ovf_i;
	logic        timer2_ovf_i;
	logic        external_convert_start_i;
	logic        sar_done_i;
	logic [11:0] sar_result_i;
	logic        window_match_i;
	logic [1:0]  repeat_count_i;
	logic        conv_start_o;
	logic        converter_enable_o;
	logic        burst_enable_o;
	logic        seq_done_o;
	int          n_mismatch = 0;
	int          compares = 0;
	logic [7:0]  d;
	logic [7:0]  regs [3] = '{8'hBD, 8'hBE, 8'hE8};
	// Full scale and a mixed pattern in both justifications, zero right-justified, 123 left-justified
	arf_row_s    rows [6] = '{'{1'b0, 12'hFFF, 8'h0F, 8'hFF},
		'{1'b0, 12'hA5C, 8'h0A, 8'h5C}, '{1'b1, 12'hFFF, 8'hFF, 8'hF0},
		'{1'b1, 12'hA5C, 8'hA5, 8'hC0}, '{1'b0, 12'h000, 8'h00, 8'h00},
		'{1'b1, 12'h123, 8'h12, 8'h30}};
	// Largest sums that still fit the width each repeat code implies
	logic [11:0] rres [3] = '{12'h7FF, 12'h7FF, 12'hFFF};
	logic [15:0] rsum [3] = '{16'h1FFC, 16'h3FF8, 16'hFFF0};

	always #5 ref_clk_i = ~ref_clk_i;

	arf_ctrl u_dut
	(
		.ref_clk_i                (ref_clk_i),
		.resetn_i                 (resetn_i),
		.sfr_page_i               (sfr_page_i),
		.sfr_addr_i               (sfr_addr_i),
		.sfr_wr_i                 (sfr_wr_i),
		.sfr_rd_i                 (sfr_rd_i),
		.sfr_wdata_i              (sfr_wdata_i),
		.sfr_bit_wr_i             (sfr_bit_wr_i),
		.sfr_bit_addr_i           (sfr_bit_addr_i),
		.sfr_bit_val_i            (sfr_bit_val_i),
		.sfr_rdata_o              (sfr_rdata_o),
		.timer1_ovf_i             (timer1_ovf_i),
		.timer2_ovf_i             (timer2_ovf_i),
		.external_convert_start_i (external_convert_start_i),
		.sar_done_i               (sar_done_i),
		.sar_result_i             (sar_result_i),
		.window_match_i           (window_match_i),
		.repeat_count_i           (repeat_count_i),
		.conv_start_o             (conv_start_o),
		.converter_enable_o       (converter_enable_o),
		.burst_enable_o           (burst_enable_o),
		.seq_done_o               (seq_done_o)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		sfr_wr_i <= 1'b1;
		sfr_addr_i <= a;
		sfr_wdata_i <= v;
		@(posedge ref_clk_i);
		sfr_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk_i);
		sfr_rd_i <= 1'b1;
		sfr_addr_i <= a;
		@(posedge ref_clk_i);
		sfr_rd_i <= 1'b0;
		#1;
		v = sfr_rdata_o;
	endtask

	task automatic bitwr(input logic [7:0] a, input logic v);
		@(posedge ref_clk_i);
		sfr_bit_wr_i <= 1'b1;
		sfr_bit_addr_i <= a;
		sfr_bit_val_i <= v;
		@(posedge ref_clk_i);
		sfr_bit_wr_i <= 1'b0;
	endtask

	task automatic trig(input int k);
		@(posedge ref_clk_i);
		timer1_ovf_i <= (k == 1);
		external_convert_start_i <= (k == 2);
		timer2_ovf_i <= (k == 3);
		@(posedge ref_clk_i);
		{timer1_ovf_i, external_convert_start_i, timer2_ovf_i} <= 3'h0;
	endtask

	// A start pulse lasts one cycle, so it is looked at just after each edge
	task automatic wait_start(input int n, input logic want);
		int k;
		for (k = 0; k < n; k++)
		begin
			#1;
			if (conv_start_o === 1'b1 && want)
				return;
			if (!want)
				chk({7'h0, conv_start_o}, 8'h00);
			@(posedge ref_clk_i);
		end
		if (want)
		begin
			n_mismatch++;
			$display("BAD %0t no conversion start", $time);
			stop_test();
		end
	endtask

	task automatic run_conv(input logic [11:0] res, input logic win,
		input logic fin);
		wait_start(20, 1'b1);
		@(posedge ref_clk_i);
		sar_done_i <= 1'b1;
		sar_result_i <= res;
		window_match_i <= win;
		@(posedge ref_clk_i);
		sar_done_i <= 1'b0;
		window_match_i <= 1'b0;
		sar_result_i <= ~res;
		#1;
		chk({7'h0, seq_done_o}, {7'h0, fin});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		resetn_i = 1'b0;
		{sfr_page_i, sfr_addr_i, sfr_wdata_i, sfr_bit_addr_i} = 32'h0;
		{sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i} = 4'h0;
		{timer1_ovf_i, timer2_ovf_i, external_convert_start_i} = 3'h0;
		{sar_done_i, window_match_i, sar_result_i} = 14'h0;
		repeat_count_i = 2'h0;
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			rd(regs[i], d);
			chk(d, 8'h00);
		end
		// Repeat stays at single whenever left justification is used
		for (int i = 0; i < 6; i++)
		begin
			wr(arf_pkg::ADDR_CTRL, {5'b10010, rows[i].lj, 2'b00});
			run_conv(rows[i].res, i[0], 1'b1);
			rd(arf_pkg::ADDR_RES_HIGH, d);
			chk(d, rows[i].hi);
			rd(arf_pkg::ADDR_RES_LOW, d);
			chk(d, rows[i].lo);
			rd(arf_pkg::ADDR_CTRL, d);
			chk(d, {4'hA, i[0], rows[i].lj, 2'b00});
		end
		@(posedge ref_clk_i);
		#1;
		chk(sfr_rdata_o, 8'h00);
		repeat (20) @(posedge ref_clk_i);
		rd(arf_pkg::ADDR_CTRL, d);
		chk(d & 8'h20, 8'h20);
		bitwr(8'hED, 1'b0);
		rd(arf_pkg::ADDR_CTRL, d);
		chk(d & 8'h20, 8'h00);
		bitwr(8'hEC, 1'b1);
		run_conv(12'h5A3, 1'b0, 1'b1);
		rd(arf_pkg::ADDR_RES_LOW, d);
		chk(d, 8'h30);
		// Busy write without enable must not start anything
		wr(arf_pkg::ADDR_CTRL, 8'h10);
		wait_start(6, 1'b0);
		wr(arf_pkg::ADDR_CTRL, 8'hC0);
		@(posedge ref_clk_i);
		#1;
		chk({6'h0, converter_enable_o, burst_enable_o}, 8'h03);
		// Sums of 4 started one by one, 8 and 16 in burst
		for (int r = 1; r < 4; r++)
		begin
			repeat_count_i <= r[1:0];
			wr(arf_pkg::ADDR_CTRL, (r == 1) ? 8'h90 : 8'hD0);
			for (int k = 0; k < (2 << r); k++)
			begin
				if (r == 1 && k > 0)
					bitwr(8'hEC, 1'b1);
				run_conv(rres[r - 1], 1'b0, k == (2 << r) - 1);
			end
			rd(arf_pkg::ADDR_RES_HIGH, d);
			chk(d, rsum[r - 1][15:8]);
			rd(arf_pkg::ADDR_RES_LOW, d);
			chk(d, rsum[r - 1][7:0]);
		end
		repeat_count_i <= 2'h0;
		// Each hardware source, after a trigger from a source not selected
		for (int s = 1; s < 4; s++)
		begin
			wr(arf_pkg::ADDR_CTRL, {6'b100000, s[1:0]});
			trig((s % 3) + 1);
			wait_start(6, 1'b0);
			trig(s);
			run_conv(12'h3C5, 1'b0, 1'b1);
		end
		@(posedge ref_clk_i);
		sfr_page_i <= 8'h01;
		wr(arf_pkg::ADDR_RES_LOW, 8'h55);
		rd(arf_pkg::ADDR_RES_LOW, d);
		chk(d, 8'h00);
		@(posedge ref_clk_i);
		sfr_page_i <= 8'h00;
		rd(arf_pkg::ADDR_RES_LOW, d);
		chk(d, 8'hC5);
		rd(8'hBF, d);
		chk(d, 8'h00);
		wr(arf_pkg::ADDR_RES_LOW, 8'h3C);
		rd(arf_pkg::ADDR_RES_LOW, d);
		chk(d, 8'h3C);
		// Second reset in mid-run clears registers and outputs
		@(posedge ref_clk_i);
		resetn_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk({6'h0, converter_enable_o, burst_enable_o}, 8'h00);
		@(posedge ref_clk_i);
		resetn_i <= 1'b1;
		rd(arf_pkg::ADDR_CTRL, d);
		chk(d, 8'h00);
		rd(arf_pkg::ADDR_RES_LOW, d);
		chk(d, 8'h00);
		stop_test();
	end
endmodule

//--- arf_fmt_if.sv
// Carrier between the control logic and the result formatter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface arf_fmt_if;
	logic [arf_pkg::ACC_W-1:0] acc;
	logic                      ljust;
	logic [1:0]                rpt;
	logic [7:0]                hi;
	logic [7:0]                lo;
	modport ctrl (output acc, output ljust, output rpt, input hi, input lo);
	modport fmt  (input acc, input ljust, input rpt, output hi, output lo);
endinterface

//--- arf_format.sv
// Maps the accumulated sum onto the high/low result byte pair.
// Assumes the sum never exceeds the width implied by the repeat code.
`timescale 1ns/1ps
module arf_format
(
	input  wire logic ref_clk_i, // System clock, assertions only
	input  wire logic resetn_i,  // Async reset, active low
	arf_fmt_if.fmt    f          // Sum in, bytes out
);
	logic [7:0] mask;

	always_comb
	begin
		case (f.rpt)
			arf_pkg::RPT_1:  mask = arf_pkg::MASK_RPT_1;
			arf_pkg::RPT_4:  mask = arf_pkg::MASK_RPT_4;
			arf_pkg::RPT_8:  mask = arf_pkg::MASK_RPT_8;
			default:         mask = arf_pkg::MASK_RPT_16;
		endcase
		if (f.ljust)
		begin
			// Only meaningful for a single conversion
			f.hi = f.acc[11:4];
			f.lo = {f.acc[3:0], 4'h0};
		end
		else
		begin
			// Mask keeps unused upper bits zero even on overflow
			f.hi = f.acc[15:8] & mask;
			f.lo = f.acc[7:0];
		end
	end

	right_single_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(!f.ljust && f.rpt == 2'h0) |-> (f.hi == {4'h0, f.acc[11:8]}))
		else $error("single right-justified high byte wrong");
	right_acc_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(!f.ljust && f.rpt == 2'h1) |-> (f.hi[7:5] == 3'h0))
		else $error("four-sum high byte upper bits not zero");
	left_bytes_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		f.ljust |-> (f.lo == {f.acc[3:0], 4'h0} && f.hi == f.acc[11:4]))
		else $error("left-justified bytes wrong");
endmodule

//--- arf_pkg.sv
// Constants shared by the converter result-format and control logic.
// Assumes an 8-bit special function register space with paged access.
package arf_pkg;
	localparam int          RES_W         = 12;
	localparam int          ACC_W         = 16;
	localparam logic [7:0]  ADDR_RES_LOW  = 8'hBD;
	localparam logic [7:0]  ADDR_RES_HIGH = 8'hBE;
	localparam logic [7:0]  ADDR_CTRL     = 8'hE8;
	localparam logic [7:0]  SFR_PAGE      = 8'h00;
	localparam logic [7:0]  RST_RES_LOW   = 8'h00;
	localparam logic [7:0]  RST_RES_HIGH  = 8'h00;
	localparam logic [7:0]  RST_CTRL      = 8'h00;
	// Control register field positions
	localparam int          CN_ENABLE     = 7;
	localparam int          CN_BURST      = 6;
	localparam int          CN_DONE       = 5;
	localparam int          CN_BUSY       = 4;
	localparam int          CN_WINDOW     = 3;
	localparam int          CN_LJUST      = 2;
	localparam int          CN_CM_HI      = 1;
	localparam int          CN_CM_LO      = 0;
	// Start source codes
	localparam logic [1:0]  CM_SOFTWARE   = 2'h0;
	localparam logic [1:0]  CM_TIMER1     = 2'h1;
	localparam logic [1:0]  CM_EXTERNAL   = 2'h2;
	localparam logic [1:0]  CM_TIMER2     = 2'h3;
	// Repeat codes and high-byte masks for right justification
	localparam logic [1:0]  RPT_1         = 2'h0;
	localparam logic [1:0]  RPT_4         = 2'h1;
	localparam logic [1:0]  RPT_8         = 2'h2;
	localparam logic [1:0]  RPT_16        = 2'h3;
	localparam logic [7:0]  MASK_RPT_1    = 8'h0F;
	localparam logic [7:0]  MASK_RPT_4    = 8'h1F;
	localparam logic [7:0]  MASK_RPT_8    = 8'h3F;
	localparam logic [7:0]  MASK_RPT_16   = 8'hFF;
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_TRIG} arf_state_e;
endpackage
